// [logic/bsc_device.sv]
// How it works
// - version query answers eight ASCII characters
// - B0h echoed, then 9600 or 9615
// - B1h echoed, then 19200 or 19230
// - B2h echoed, then 38400 or 38461
// - B3h echoed, then 57600 or 55555
// - B4h echoed for 115200, mode 2 only
// - new rate applies after echo fully sent
// - B5h divider byte echoed, then loaded
// - divider gives rate from 8 MHz/16
// - programmer keeps minimum gaps between bytes
// - programmer scales gaps to device clock
// - half-duplex turnaround waits and releases line
// - status read reports finished operation outcome
// - status read returns main then extended
// - ready bit seven, erase five, program four
`timescale 1ns/1ps
module bsc_device
  import bsc_pkg::*;
#(
  parameter logic [63:0] VERSION = "VER.1.00",
  parameter int TURN_CYC = TURN_WAIT_US * CLK_MHZ
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic MODE3,
  input wire logic SEQ_READY,
  input wire logic PROG_ERR,
  input wire logic ERASE_ERR,
  input wire logic [1:0] ID_CHECK,
  bsc_link_if.dev LINK,
  output logic CMD_VALID,
  output logic [7:0] CMD_CODE
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GET_DIV = 2'b01,
    ST_TURN = 2'b10,
    ST_SEND = 2'b11
  } bsc_dev_state_t;

  logic [15:0] bit_cyc;
  logic rx_busy_q, rx_busy_d, rx_valid_q, rx_valid_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  logic tx_busy_q, tx_busy_d, tx_start, tx_done;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [7:0] tx_byte, main_status, ext_status;
  bsc_dev_state_t st_q, st_d;
  bsc_kind_t kind_q, kind_d;
  logic [2:0] idx_q, idx_d, last_q, last_d, sel_q, sel_d, pend_sel_q, pend_sel_d;
  logic [7:0] echo_q, echo_d, div_q, div_d, cmd_code_q, cmd_code_d;
  logic pend_q, pend_d, cmd_valid_q, cmd_valid_d;
  logic [TURN_W-1:0] turn_q, turn_d;

  assign bit_cyc = bit_cycles(sel_q, div_q, MODE3);

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  always_comb begin
    rx_busy_d = rx_busy_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_valid_d = 1'b0;
    rx_byte_d = rx_byte_q;
    if (!rx_busy_q) begin
      if (!LINK.to_dev) begin
        rx_busy_d = 1'b1;
        rx_cnt_d = bit_cyc >> 1;
        rx_bit_d = START_IDX;
      end
    end else if (rx_cnt_q != '0) begin
      rx_cnt_d = rx_cnt_q - CYC_ONE;
    end else begin
      rx_cnt_d = bit_cyc - CYC_ONE;
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == START_IDX) begin
        // Glitch shorter than half a bit is no start
        if (LINK.to_dev) begin
          rx_busy_d = 1'b0;
        end
      end else if (rx_bit_q == STOP_IDX) begin
        rx_busy_d = 1'b0;
        rx_valid_d = LINK.to_dev;
        rx_byte_d = rx_sh_q;
      end else begin
        rx_sh_d = {LINK.to_dev, rx_sh_q[7:1]};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= START_IDX;
      rx_sh_q <= '0;
      rx_valid_q <= 1'b0;
      rx_byte_q <= '0;
    end else begin
      rx_busy_q <= rx_busy_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_valid_q <= rx_valid_d;
      rx_byte_q <= rx_byte_d;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  always_comb begin
    main_status = '0;
    main_status[ST_READY_BIT] = SEQ_READY;
    main_status[ST_ERASE_BIT] = ERASE_ERR;
    main_status[ST_PROG_BIT] = PROG_ERR;
    ext_status = '0;
    ext_status[EXT_ID_LSB +: 2] = ID_CHECK;
    case (kind_q)
      KIND_VERSION: tx_byte = VERSION[63 - 8 * int'(idx_q) -: 8];
      KIND_STATUS: tx_byte = (idx_q == '0) ? main_status : ext_status;
      default: tx_byte = echo_q;
    endcase
  end

  assign tx_start = (st_q == ST_SEND) && !tx_busy_q;
  assign tx_done = tx_busy_q && (tx_cnt_q == '0) && (tx_bit_q == STOP_IDX);

  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    if (!tx_busy_q) begin
      if (tx_start) begin
        tx_busy_d = 1'b1;
        tx_sh_d = {1'b1, tx_byte, 1'b0};
        tx_cnt_d = bit_cyc - CYC_ONE;
        tx_bit_d = START_IDX;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_d = tx_cnt_q - CYC_ONE;
    end else begin
      tx_cnt_d = bit_cyc - CYC_ONE;
      tx_bit_d = tx_bit_q + 4'h1;
      tx_sh_d = {1'b1, tx_sh_q[9:1]};
      if (tx_bit_q == STOP_IDX) begin
        tx_busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= START_IDX;
      tx_sh_q <= '1;
    end else begin
      tx_busy_q <= tx_busy_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
    end
  end

  assign LINK.dev_txd = tx_sh_q[0];
  // Half duplex: drive only while a frame is out, release at its end
  assign LINK.dev_oe = MODE3 ? tx_busy_q : 1'b1;

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    idx_d = idx_q;
    last_d = last_q;
    echo_d = echo_q;
    pend_d = pend_q;
    pend_sel_d = pend_sel_q;
    sel_d = sel_q;
    div_d = div_q;
    turn_d = turn_q;
    cmd_valid_d = 1'b0;
    cmd_code_d = cmd_code_q;
    case (st_q)
      ST_IDLE: begin
        if (rx_valid_q) begin
          idx_d = '0;
          last_d = '0;
          echo_d = rx_byte_q;
          kind_d = KIND_ECHO;
          pend_d = 1'b0;
          pend_sel_d = 3'(rx_byte_q - CMD_RATE_9600);
          turn_d = TURN_W'(TURN_CYC - 1);
          cmd_code_d = rx_byte_q;
          cmd_valid_d = 1'b1;
          st_d = MODE3 ? ST_TURN : ST_SEND;
          case (rx_byte_q)
            CMD_VERSION: begin
              kind_d = KIND_VERSION;
              last_d = VERSION_LAST;
            end
            CMD_STATUS: begin
              kind_d = KIND_STATUS;
              last_d = STATUS_LAST;
            end
            CMD_RATE_9600, CMD_RATE_19200, CMD_RATE_38400, CMD_RATE_57600: begin
              pend_d = 1'b1;
            end
            CMD_RATE_115200: begin
              // Not offered in mode 3: dropped like any unknown byte
              if (MODE3) begin
                st_d = ST_IDLE;
                cmd_valid_d = 1'b0;
              end else begin
                pend_d = 1'b1;
              end
            end
            CMD_RATE_SET: begin
              st_d = ST_GET_DIV;
            end
            default: begin
              st_d = ST_IDLE;
              cmd_valid_d = 1'b0;
            end
          endcase
        end
      end
      ST_GET_DIV: begin
        if (rx_valid_q) begin
          echo_d = rx_byte_q;
          pend_d = 1'b1;
          pend_sel_d = SEL_CUSTOM;
          turn_d = TURN_W'(TURN_CYC - 1);
          st_d = MODE3 ? ST_TURN : ST_SEND;
        end
      end
      ST_TURN: begin
        if (turn_q != '0) begin
          turn_d = turn_q - TURN_W'(1);
        end else begin
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_done) begin
          idx_d = idx_q + 3'h1;
          if (idx_q == last_q) begin
            st_d = ST_IDLE;
            // Rate switches only once the stop bit of the echo is out
            if (pend_q) begin
              sel_d = pend_sel_q;
              div_d = echo_q;
              pend_d = 1'b0;
            end
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= ST_IDLE;
      kind_q <= KIND_ECHO;
      idx_q <= '0;
      last_q <= '0;
      echo_q <= '0;
      pend_q <= 1'b0;
      pend_sel_q <= SEL_9600;
      sel_q <= SEL_9600;
      div_q <= DIV_RESET;
      turn_q <= '0;
      cmd_valid_q <= 1'b0;
      cmd_code_q <= '0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      idx_q <= idx_d;
      last_q <= last_d;
      echo_q <= echo_d;
      pend_q <= pend_d;
      pend_sel_q <= pend_sel_d;
      sel_q <= sel_d;
      div_q <= div_d;
      turn_q <= turn_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_code_q <= cmd_code_d;
    end
  end

  assign CMD_VALID = cmd_valid_q;
  assign CMD_CODE = cmd_code_q;
endmodule

// [logic/bsc_host.sv]
`timescale 1ns/1ps
module bsc_host
  import bsc_pkg::*;
#(
  parameter int DEV_CLK_MHZ = 8,
  parameter int GAP_DATA_CYC = GAP_DATA_US * CLK_MHZ * DEV_REF_MHZ / DEV_CLK_MHZ,
  parameter int GAP_CMD_CYC = GAP_CMD_NS * CLK_MHZ * DEV_REF_MHZ / DEV_CLK_MHZ / 1000
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic MODE3,
  input wire logic REQ_VALID,
  input wire logic [7:0] REQ_BYTE,
  input wire logic REQ_IS_DATA,
  output logic REQ_READY,
  output logic REQ_REFUSED,
  bsc_link_if.host LINK,
  output logic RSP_VALID,
  output logic [7:0] RSP_BYTE
);
  logic [15:0] bit_cyc;
  logic rx_busy_q, rx_busy_d, rx_valid_q, rx_valid_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  logic tx_busy_q, tx_busy_d, take, refuse_q, refuse_d, forbid;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [GAP_W-1:0] gap_q, gap_d, gap_need;
  logic [2:0] sel_q, sel_d, pend_sel_q, pend_sel_d;
  logic [7:0] div_q, div_d, pend_echo_q, pend_echo_d;
  logic pend_q, pend_d, want_div_q, want_div_d;

  assign bit_cyc = bit_cycles(sel_q, div_q, MODE3);
  assign gap_need = REQ_IS_DATA ? GAP_W'(GAP_DATA_CYC) : GAP_W'(GAP_CMD_CYC);
  assign forbid = MODE3 && !REQ_IS_DATA && !want_div_q && (REQ_BYTE == CMD_RATE_115200);
  // In mode 3 the line is only taken while the device is silent
  assign REQ_READY = !tx_busy_q && (gap_q >= gap_need) && !(MODE3 && rx_busy_q);
  assign take = REQ_VALID && REQ_READY && !forbid;

  // ---------------------------------------------------------------
  // Receiver and rate tracking
  // ---------------------------------------------------------------
  always_comb begin
    rx_busy_d = rx_busy_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_valid_d = 1'b0;
    rx_byte_d = rx_byte_q;
    if (!rx_busy_q) begin
      if (!LINK.to_host) begin
        rx_busy_d = 1'b1;
        rx_cnt_d = bit_cyc >> 1;
        rx_bit_d = START_IDX;
      end
    end else if (rx_cnt_q != '0) begin
      rx_cnt_d = rx_cnt_q - CYC_ONE;
    end else begin
      rx_cnt_d = bit_cyc - CYC_ONE;
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == START_IDX) begin
        if (LINK.to_host) begin
          rx_busy_d = 1'b0;
        end
      end else if (rx_bit_q == STOP_IDX) begin
        rx_busy_d = 1'b0;
        rx_valid_d = LINK.to_host;
        rx_byte_d = rx_sh_q;
      end else begin
        rx_sh_d = {LINK.to_host, rx_sh_q[7:1]};
      end
    end
  end

  always_comb begin
    sel_d = sel_q;
    div_d = div_q;
    pend_d = pend_q;
    pend_sel_d = pend_sel_q;
    pend_echo_d = pend_echo_q;
    want_div_d = want_div_q;
    refuse_d = REQ_VALID && REQ_READY && forbid;
    if (take) begin
      if (want_div_q) begin
        want_div_d = 1'b0;
        pend_d = 1'b1;
        pend_sel_d = SEL_CUSTOM;
        pend_echo_d = REQ_BYTE;
      end else if (!REQ_IS_DATA && REQ_BYTE == CMD_RATE_SET) begin
        want_div_d = 1'b1;
      end else if (!REQ_IS_DATA && REQ_BYTE >= CMD_RATE_9600 && REQ_BYTE <= CMD_RATE_115200) begin
        pend_d = 1'b1;
        pend_sel_d = 3'(REQ_BYTE - CMD_RATE_9600);
        pend_echo_d = REQ_BYTE;
      end
    end else if (rx_valid_q && pend_q && rx_byte_q == pend_echo_q) begin
      // Device switches after its echo, so follow it here
      sel_d = pend_sel_q;
      div_d = pend_echo_q;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= START_IDX;
      rx_sh_q <= '0;
      rx_valid_q <= 1'b0;
      rx_byte_q <= '0;
      sel_q <= SEL_9600;
      div_q <= DIV_RESET;
      pend_q <= 1'b0;
      pend_sel_q <= SEL_9600;
      pend_echo_q <= '0;
      want_div_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      rx_busy_q <= rx_busy_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_valid_q <= rx_valid_d;
      rx_byte_q <= rx_byte_d;
      sel_q <= sel_d;
      div_q <= div_d;
      pend_q <= pend_d;
      pend_sel_q <= pend_sel_d;
      pend_echo_q <= pend_echo_d;
      want_div_q <= want_div_d;
      refuse_q <= refuse_d;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter and byte spacing
  // ---------------------------------------------------------------
  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    gap_d = (gap_q == '1) ? gap_q : gap_q + GAP_W'(1);
    if (!tx_busy_q) begin
      if (take) begin
        tx_busy_d = 1'b1;
        tx_sh_d = {1'b1, REQ_BYTE, 1'b0};
        tx_cnt_d = bit_cyc - CYC_ONE;
        tx_bit_d = START_IDX;
      end
    end else begin
      gap_d = '0;
      if (tx_cnt_q != '0) begin
        tx_cnt_d = tx_cnt_q - CYC_ONE;
      end else begin
        tx_cnt_d = bit_cyc - CYC_ONE;
        tx_bit_d = tx_bit_q + 4'h1;
        tx_sh_d = {1'b1, tx_sh_q[9:1]};
        if (tx_bit_q == STOP_IDX) begin
          tx_busy_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= START_IDX;
      tx_sh_q <= '1;
      gap_q <= '1;
    end else begin
      tx_busy_q <= tx_busy_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      gap_q <= gap_d;
    end
  end

  assign LINK.host_txd = tx_sh_q[0];
  assign LINK.host_oe = MODE3 ? tx_busy_q : 1'b1;
  assign REQ_REFUSED = refuse_q;
  assign RSP_VALID = rx_valid_q;
  assign RSP_BYTE = rx_byte_q;
endmodule

// [logic/bsc_link_if.sv]
`timescale 1ns/1ps
interface bsc_link_if;
  logic host_txd;
  logic host_oe;
  logic dev_txd;
  logic dev_oe;
  logic to_dev;
  logic to_host;

  // Undriven line idles high
  assign to_dev = host_oe ? host_txd : 1'b1;
  assign to_host = dev_oe ? dev_txd : 1'b1;

  modport dev (input to_dev, output dev_txd, output dev_oe);
  modport host (input to_host, output host_txd, output host_oe);
endinterface

// [logic/bsc_pkg.sv]
package bsc_pkg;
  // ---------------------------------------------------------------
  // Clock and link framing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_MHZ = 40;
  localparam int BRG_CLK_HZ = 8_000_000;
  localparam int BRG_PRESCALE = 16;
  localparam int DIV_UNIT_CYC = CLK_HZ / BRG_CLK_HZ * BRG_PRESCALE;
  localparam logic [3:0] START_IDX = 4'h0;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [15:0] CYC_ONE = 16'h0001;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_VERSION = 8'hFB;
  localparam logic [7:0] CMD_RATE_9600 = 8'hB0;
  localparam logic [7:0] CMD_RATE_19200 = 8'hB1;
  localparam logic [7:0] CMD_RATE_38400 = 8'hB2;
  localparam logic [7:0] CMD_RATE_57600 = 8'hB3;
  localparam logic [7:0] CMD_RATE_115200 = 8'hB4;
  localparam logic [7:0] CMD_RATE_SET = 8'hB5;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [2:0] VERSION_LAST = 3'h7;
  localparam logic [2:0] STATUS_LAST = 3'h1;

  // ---------------------------------------------------------------
  // Rate selection
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_9600 = 3'h0;
  localparam logic [2:0] SEL_19200 = 3'h1;
  localparam logic [2:0] SEL_38400 = 3'h2;
  localparam logic [2:0] SEL_57600 = 3'h3;
  localparam logic [2:0] SEL_115200 = 3'h4;
  localparam logic [2:0] SEL_CUSTOM = 3'h5;
  localparam int RATE_9600 = 9600;
  localparam int RATE_19200 = 19200;
  localparam int RATE_38400 = 38400;
  localparam int RATE_57600 = 57600;
  localparam int RATE_115200 = 115200;
  localparam logic [7:0] DIV_M3_9615 = 8'h33;
  localparam logic [7:0] DIV_M3_19230 = 8'h19;
  localparam logic [7:0] DIV_M3_38461 = 8'h0C;
  localparam logic [7:0] DIV_M3_55555 = 8'h08;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Status byte layout and timing
  // ---------------------------------------------------------------
  localparam int ST_READY_BIT = 7;
  localparam int ST_ERASE_BIT = 5;
  localparam int ST_PROG_BIT = 4;
  localparam int EXT_ID_LSB = 2;
  localparam int TURN_WAIT_US = 2000;
  localparam int GAP_DATA_US = 20000;
  localparam int GAP_CMD_NS = 5000;
  localparam int DEV_REF_MHZ = 8;
  localparam int TURN_W = 20;
  localparam int GAP_W = 24;

  typedef enum logic [1:0] {
    KIND_VERSION = 2'b00,
    KIND_ECHO = 2'b01,
    KIND_STATUS = 2'b10
  } bsc_kind_t;

  function automatic logic [15:0] cyc_of_rate(input int rate);
    return 16'(CLK_HZ / rate);
  endfunction

  function automatic logic [15:0] cyc_of_div(input logic [7:0] div);
    return 16'((int'(div) + 1) * DIV_UNIT_CYC);
  endfunction

  function automatic logic [15:0] bit_cycles(input logic [2:0] sel, input logic [7:0] div,
                                             input logic mode3);
    case (sel)
      SEL_9600: return mode3 ? cyc_of_div(DIV_M3_9615) : cyc_of_rate(RATE_9600);
      SEL_19200: return mode3 ? cyc_of_div(DIV_M3_19230) : cyc_of_rate(RATE_19200);
      SEL_38400: return mode3 ? cyc_of_div(DIV_M3_38461) : cyc_of_rate(RATE_38400);
      SEL_57600: return mode3 ? cyc_of_div(DIV_M3_55555) : cyc_of_rate(RATE_57600);
      SEL_115200: return cyc_of_rate(RATE_115200);
      default: return cyc_of_div(div);
    endcase
  endfunction
endpackage

// [tb/boot_serial_command_handler_tb_top.sv]
`timescale 1ns/1ps
module boot_serial_command_handler_tb_top;
  import bsc_pkg::*;
  localparam int TURN = 8000;
  localparam int TMO = 60000;
  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic MODE3 = 1'b0;
  logic SEQ_READY = 1'b1;
  logic PROG_ERR = 1'b0;
  logic ERASE_ERR = 1'b0;
  logic [1:0] ID_CHECK = 2'h0;
  logic REQ_VALID = 1'b0;
  logic REQ_IS_DATA = 1'b0;
  logic [7:0] REQ_BYTE = 8'h00;
  logic REQ_READY, REQ_REFUSED, RSP_VALID, CMD_VALID, last_ref;
  logic [7:0] RSP_BYTE, CMD_CODE;
  logic [63:0] ver = "VER.3.10";
  int failures = 0;
  int n_checks = 0;
  int n_cmd = 0;

  always #12.5 CORE_CLK = ~CORE_CLK;

  always @(negedge CORE_CLK) if (CMD_VALID === 1'b1) n_cmd++;

  // ---------------------------------------------------------------
  // Both ends and the wire checker
  // ---------------------------------------------------------------
  bsc_link_if i_bsc_link_if ();

  bsc_device #(.VERSION("VER.3.10"), .TURN_CYC(TURN)) i_bsc_device (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .MODE3(MODE3), .SEQ_READY(SEQ_READY),
    .PROG_ERR(PROG_ERR), .ERASE_ERR(ERASE_ERR), .ID_CHECK(ID_CHECK),
    .LINK(i_bsc_link_if.dev), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE));

  bsc_host #(.GAP_DATA_CYC(4000), .GAP_CMD_CYC(400)) i_bsc_host (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .MODE3(MODE3), .REQ_VALID(REQ_VALID),
    .REQ_BYTE(REQ_BYTE), .REQ_IS_DATA(REQ_IS_DATA), .REQ_READY(REQ_READY),
    .REQ_REFUSED(REQ_REFUSED), .LINK(i_bsc_link_if.host), .RSP_VALID(RSP_VALID),
    .RSP_BYTE(RSP_BYTE));

  bsc_link_chk #(.TURN_CYC(TURN), .GAP_CMD_CYC(400)) i_bsc_link_chk (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .MODE3(MODE3),
    .host_txd(i_bsc_link_if.host_txd), .host_oe(i_bsc_link_if.host_oe),
    .dev_txd(i_bsc_link_if.dev_txd), .dev_oe(i_bsc_link_if.dev_oe),
    .to_dev(i_bsc_link_if.to_dev), .to_host(i_bsc_link_if.to_host));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b);
    int n = 0;
    @(negedge CORE_CLK);
    while (REQ_READY !== 1'b1 && n < TMO) begin
      @(negedge CORE_CLK);
      n++;
    end
    if (n >= TMO) failures++;
    REQ_BYTE = b;
    REQ_VALID = 1'b1;
    @(negedge CORE_CLK);
    REQ_VALID = 1'b0;
    last_ref = REQ_REFUSED;
  endtask

  // Low run of an answer start bit plus its trailing zero bits
  task automatic meas(input logic [7:0] b, input int cyc);
    int n = 0;
    int k = 1;
    while (k < 9 && b[k-1] == 1'b0) k++;
    while (i_bsc_link_if.to_host !== 1'b0 && n < TMO) begin
      @(negedge CORE_CLK);
      n++;
    end
    n = 0;
    while (i_bsc_link_if.to_host === 1'b0 && n < TMO) begin
      n++;
      @(negedge CORE_CLK);
    end
    chk("low run", n, k * cyc);
  endtask

  task automatic get(input logic [7:0] exp);
    int n = 0;
    do begin
      @(negedge CORE_CLK);
      n++;
    end while (RSP_VALID !== 1'b1 && n < TMO);
    if (n >= TMO) failures++;
    chk("answer byte", RSP_BYTE, exp);
  endtask

  task automatic cmd(input logic [7:0] b, input int cyc);
    send(b);
    meas(b, cyc);
    get(b);
    chk("command code", CMD_CODE, b);
    // Let the echo stop bit finish before the device switches rate
    repeat (cyc) @(negedge CORE_CLK);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #(400000 * 25);
    failures++;
    finish_test;
  end

  initial begin
    repeat (5) @(negedge CORE_CLK);
    ARST_N = 1'b1;
    cmd(CMD_RATE_115200, CLK_HZ / RATE_9600);
    send(CMD_VERSION);
    meas(ver[63:56], CLK_HZ / RATE_115200);
    for (int i = 7; i >= 0; i--) get(ver[i*8+:8]);
    for (int i = 0; i < 2; i++) begin
      SEQ_READY = (i == 0);
      PROG_ERR = (i == 0);
      ERASE_ERR = (i == 1);
      ID_CHECK = (i == 0) ? 2'h3 : 2'h1;
      send(CMD_STATUS);
      get((i == 0) ? 8'h90 : 8'h20);
      get((i == 0) ? 8'h0C : 8'h04);
    end
    send(8'h55);
    cmd(CMD_RATE_57600, CLK_HZ / RATE_115200);
    cmd(CMD_RATE_38400, CLK_HZ / RATE_57600);
    cmd(CMD_RATE_19200, CLK_HZ / RATE_38400);
    send(CMD_RATE_SET);
    REQ_IS_DATA = 1'b1;
    send(8'h01);
    REQ_IS_DATA = 1'b0;
    meas(8'h01, CLK_HZ / RATE_19200);
    get(8'h01);
    repeat (CLK_HZ / RATE_19200) @(negedge CORE_CLK);
    cmd(CMD_RATE_9600, 2 * DIV_UNIT_CYC);
    chk("accepted commands", n_cmd, 9);
    ARST_N = 1'b0;
    MODE3 = 1'b1;
    repeat (5) @(negedge CORE_CLK);
    ARST_N = 1'b1;
    n_cmd = 0;
    send(CMD_RATE_115200);
    chk("refused", last_ref, 1);
    cmd(CMD_RATE_19200, (int'(DIV_M3_9615) + 1) * DIV_UNIT_CYC);
    chk("accepted commands", n_cmd, 1);
    finish_test;
  end
endmodule

// [tb/bsc_link_chk.sv]
`timescale 1ns/1ps
module bsc_link_chk #(
  parameter int TURN_CYC = 20,
  parameter int GAP_CMD_CYC = 20
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic MODE3,
  input wire logic host_txd,
  input wire logic host_oe,
  input wire logic dev_txd,
  input wire logic dev_oe,
  input wire logic to_dev,
  input wire logic to_host
);
  // ---------------------------------------------------------------
  // Run counters
  // ---------------------------------------------------------------
  logic [15:0] quiet_q, quiet_d, low_q, low_d;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  always_comb begin
    quiet_d = host_oe ? 16'h0000 : sat_inc(quiet_q);
    low_d = to_host ? 16'h0000 : sat_inc(low_q);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      quiet_q <= 16'hFFFF;
      low_q <= 16'h0000;
    end else begin
      quiet_q <= quiet_d;
      low_q <= low_d;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_dev_lead;
    !dev_txd ##1 dev_oe [*7];
  endsequence

  sequence s_host_lead;
    !host_txd ##1 host_oe [*7];
  endsequence

  chk_half_duplex: assert property (MODE3 |-> !(dev_oe && host_oe))
    else $error("both ends drive the link");
  chk_full_duplex_oe: assert property (!MODE3 |-> dev_oe && host_oe)
    else $error("line released in full duplex");
  chk_dev_frame_lead: assert property (MODE3 && $rose(dev_oe) |-> s_dev_lead)
    else $error("device frame without start bit");
  chk_host_frame_lead: assert property (MODE3 && $rose(host_oe) |-> s_host_lead)
    else $error("host frame without start bit");
  chk_dev_release_high: assert property ($fell(dev_oe) |-> $past(dev_txd))
    else $error("device released line before stop bit");
  chk_turn_wait: assert property (MODE3 && $rose(dev_oe) |-> quiet_q >= TURN_CYC / 2)
    else $error("device drove too soon after host release");
  chk_start_min: assert property ($rose(to_host) |-> low_q >= 16'h0050)
    else $error("device low pulse shorter than fastest bit");
  chk_low_max: assert property (!to_host |-> low_q <= 16'h9276)
    else $error("device line low beyond a slowest frame");
  chk_cmd_gap: assert property (MODE3 && $rose(host_oe) |-> quiet_q > GAP_CMD_CYC)
    else $error("host bytes closer than minimum gap");
endmodule
